// ===== rtl/scc_pkg.sv
// Package of register map, field layout, reset values and timing for the conversion control block
package scc_pkg;
    // ************************************************************
    // Register map (byte addresses)
    // ************************************************************
    localparam logic [7:0] CTRL_STATUS_OFFSET = 8'h3C;
    localparam logic [7:0] RESULT_OFFSET      = 8'h40;
    localparam logic [7:0] CLOCK_DIV_OFFSET   = 8'h44;
    localparam logic [7:0] PORT_B_DATA_OFFSET = 8'h48;
    localparam logic [7:0] PORT_B_DIR_OFFSET  = 8'h4C;
    localparam logic [7:0] PORT_D_DATA_OFFSET = 8'h50;
    localparam logic [7:0] PORT_D_DIR_OFFSET  = 8'h54;

    // ************************************************************
    // Control/status field positions
    // ************************************************************
    localparam int DONE_BIT = 7;
    localparam int IEN_BIT  = 6;
    localparam int CONT_BIT = 5;

    // ************************************************************
    // Reset values and constants
    // ************************************************************
    localparam logic [4:0] CHANNEL_OFF       = 5'h1F;
    localparam logic [4:0] CHANNEL_COUNT     = 5'h0D;
    localparam logic [4:0] CHANNEL_TWELVE    = 5'h0C;
    localparam logic [4:0] CHANNEL_HIGH_REF  = 5'h1D;
    localparam logic [4:0] CHANNEL_LOW_REF   = 5'h1E;
    localparam logic [2:0] CLOCK_DIV_RESET   = 3'h0;
    localparam logic [3:0] CONVERT_CYCLES    = 4'hE;
    localparam logic [3:0] SAR_FIRST_STEP    = 4'h2;
    localparam logic [7:0] FULL_SCALE        = 8'hFF;

    typedef enum logic [1:0] {
        SCC_IDLE    = 2'b00,
        SCC_PENDING = 2'b01,
        SCC_CONVERT = 2'b10
    } scc_state_t;

    typedef struct packed {
        logic [7:0] data;
        logic [7:0] dir;
    } scc_port_t;
endpackage

// ===== rtl/scc_port_claim.sv
// Pin ownership between the converter and one general-purpose port
`timescale 1ns/100ps
module scc_port_claim
    import scc_pkg::*;
(
    // Port registers and claim mask
    input  wire scc_port_t  regs,
    input  wire logic [7:0] claim,
    // Pins
    input  wire logic [7:0] pin_in,
    output logic [7:0]      pin_out,
    output logic [7:0]      pin_oe_n,
    output logic [7:0]      read_value
);
    always_comb begin
        // A claimed pin is forced to input, whatever the port logic says
        pin_out    = regs.data & ~claim;  // R4 R7
        pin_oe_n   = ~(regs.dir & ~claim);  // R4 R7
        // Claimed: 0 when input, latch when output direction
        read_value = (claim & regs.dir & regs.data) |
                     (~claim & ((regs.dir & regs.data) | (~regs.dir & pin_in)));  // R6 R7
    end
endmodule

// ===== rtl/scc_top.sv
// Successive-approximation conversion control with APB registers and shared-pin claim
// Functional notes
// (R1) One of 13 channels, chosen by channel select, feeds the converter.
// (R2) Finished conversion writes 8-bit result, then flags or interrupts.
// (R3) Successive approximation resolves one result bit per step.
// (R4) Selected channel pin is forced to converter input.
// (R5) Port data or direction writes do not affect the claimed pin.
// (R6) Claimed pin reads 0 if direction 0, else the data latch.
// (R7) Unselected channel pins stay ordinary port pins.
// (R8) Channel select lives in control/status at 0x3C.
// (R9) Upper supply converts to FF, lower to 00, linear between.
// (R10) Inputs beyond supplies saturate at FF or 00.
// (R11) A conversion takes exactly fourteen converter clocks.
// (R12) Conversion starts on first converter clock after a control write.
// (R13) Continuous mode converts repeatedly, loading result every time.
// (R14) Continuous results overwrite unread ones.
// (R15) Repeats continue until the continuous bit is cleared.
// (R16) Done flag set per conversion; cleared by control write or result read.
// (R17) With interrupt enabled, request at end; dropped on result read/control write.
// (R18) With interrupt enabled the done flag reads 0.
// (R19) All-ones channel select turns converter off; reset loads all ones.
// (R20) 3-bit divider gives 1,2,4,8,16; top bit set means 16.
// (R21) Control write mid-conversion abandons it and starts anew.
// (R22) Continuous mode restarts on the next converter clock after storing.
`timescale 1ns/100ps
module scc_top
    import scc_pkg::*;
(
    // Clock and reset
    input  wire logic        pclk,
    input  wire logic        presetn,
    // APB slave
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [7:0]  paddr,
    input  wire logic [31:0] pwdata,
    output logic [31:0]      prdata,
    output logic             pready,
    output logic             pslverr,
    // Analog comparator: high while input exceeds trial code
    input  wire logic        cmp_above,
    output logic [7:0]       trial_code,
    output logic [4:0]       mux_select,
    output logic             converter_on,
    // Port pins
    input  wire logic [7:0]  port_b_pins_in,
    output logic [7:0]       port_b_pins_out,
    output logic [7:0]       port_b_pins_oe_n,
    input  wire logic [3:0]  port_d_pins_in,
    output logic [3:0]       port_d_pins_out,
    output logic [3:0]       port_d_pins_oe_n,
    // Interrupt request
    output logic             done_irq
);
    // ************************************************************
    // Register state
    // ************************************************************
    logic [4:0]  channel_select, next_channel_select;
    logic        continuous_convert_bit, next_continuous_convert_bit;
    logic        done_interrupt_enable, next_done_interrupt_enable;
    logic        conversion_done_flag, next_conversion_done_flag;
    logic [2:0]  converter_clock_divide, next_converter_clock_divide;
    logic [7:0]  result, next_result;
    scc_port_t   port_b, next_port_b, port_d, next_port_d;
    logic [31:0] next_prdata;
    logic        next_irq, next_pready;

    // ************************************************************
    // Converter state
    // ************************************************************
    scc_state_t  state, next_state;
    logic [3:0]  div_count, next_div_count;
    logic [3:0]  step, next_step;
    logic [7:0]  sar, next_sar;
    logic [7:0]  trial_bit, next_trial_bit;
    logic [7:0]  next_trial_code;
    logic        next_converter_on;
    logic [4:0]  next_mux_select;

    logic        wr_en, rd_en, ctrl_write, result_read, tick, finish;
    logic [3:0]  div_limit;
    logic [7:0]  claim_b, b_read;
    logic [7:0]  claim_d8, d_read8, d_out8, d_oe8;
    logic [7:0]  port_b_out_c, port_b_oe_c;
    logic [7:0]  trial_now;

    assign wr_en       = psel & penable & pready & pwrite;
    assign rd_en       = psel & penable & ~pwrite;
    assign ctrl_write  = wr_en & (paddr == CTRL_STATUS_OFFSET);  // R8
    assign result_read = rd_en & pready & (paddr == RESULT_OFFSET);

    // ************************************************************
    // Converter clock divider
    // ************************************************************
    always_comb begin
        // Any setting with the top bit set selects divide by 16
        case (converter_clock_divide)  // R20
            3'h0:    div_limit = 4'h0;
            3'h1:    div_limit = 4'h1;
            3'h2:    div_limit = 4'h3;
            3'h3:    div_limit = 4'h7;
            default: div_limit = 4'hF;
        endcase
        tick           = (div_count >= div_limit);
        next_div_count = tick ? 4'h0 : div_count + 4'h1;
    end

    // ************************************************************
    // Pin claim
    // ************************************************************
    always_comb begin
        claim_b  = 8'h00;
        claim_d8 = 8'h00;
        // Port D channels 8..11 map to pins 3 down to 0
        if (channel_select < 5'h08) begin  // R4
            claim_b[channel_select[2:0]] = 1'b1;
        end else if (channel_select < CHANNEL_TWELVE) begin
            claim_d8[3 - channel_select[1:0]] = 1'b1;
        end
    end

    scc_port_claim u_claim_b (
        .regs       (port_b),
        .claim      (claim_b),
        .pin_in     (port_b_pins_in),
        .pin_out    (port_b_out_c),
        .pin_oe_n   (port_b_oe_c),
        .read_value (b_read)
    );

    scc_port_claim u_claim_d (
        .regs       (port_d),
        .claim      (claim_d8),
        .pin_in     ({4'h0, port_d_pins_in}),
        .pin_out    (d_out8),
        .pin_oe_n   (d_oe8),
        .read_value (d_read8)
    );

    // ************************************************************
    // Successive approximation sequencer
    // ************************************************************
    assign trial_now = sar | trial_bit;
    assign finish    = (state == SCC_CONVERT) & tick & (step == CONVERT_CYCLES - 4'h1);

    always_comb begin
        next_state      = state;
        next_step       = step;
        next_sar        = sar;
        next_trial_bit  = trial_bit;
        next_trial_code = trial_code;
        next_result     = result;
        if (ctrl_write) begin
            // Restart pends on the next converter clock; running conversion dropped
            next_state = (pwdata[4:0] == CHANNEL_OFF) ? SCC_IDLE : SCC_PENDING;  // R12 R21 R19
            if (finish) next_result = sar;  // R2
        end else begin
            case (state)
                SCC_IDLE:    next_state = SCC_IDLE;
                SCC_PENDING: begin
                    if (tick) begin  // R12
                        next_state     = SCC_CONVERT;
                        next_step      = 4'h0;
                        next_sar       = 8'h00;
                        next_trial_bit = 8'h80;
                    end
                end
                SCC_CONVERT: begin
                    if (tick) begin
                        next_step = step + 4'h1;  // R11
                        // Two sample, eight trial, four settle clocks; a code stands a clock before it is judged
                        if (step == SAR_FIRST_STEP - 4'h1) next_trial_code = trial_now;
                        if (step >= SAR_FIRST_STEP && step < SAR_FIRST_STEP + 4'h8) begin
                            if (cmp_above) begin  // R3 R9 R10
                                next_sar = trial_now;
                            end
                            next_trial_bit  = trial_bit >> 1;
                            next_trial_code = (cmp_above ? trial_now : sar) | (trial_bit >> 1);
                        end
                        if (finish) begin
                            next_result = sar;  // R2 R13 R14
                            next_step   = 4'h0;
                            next_sar    = 8'h00;
                            next_trial_bit = 8'h80;
                            next_state  = continuous_convert_bit ? SCC_CONVERT : SCC_IDLE;  // R13 R15 R22
                        end
                    end
                end
                default: next_state = SCC_IDLE;
            endcase
        end
        next_mux_select   = channel_select;  // R1
        next_converter_on = (channel_select != CHANNEL_OFF);  // R19
    end

    // ************************************************************
    // APB register file
    // ************************************************************
    always_comb begin
        next_channel_select         = channel_select;
        next_continuous_convert_bit = continuous_convert_bit;
        next_done_interrupt_enable  = done_interrupt_enable;
        next_converter_clock_divide = converter_clock_divide;
        next_port_b                 = port_b;
        next_port_d                 = port_d;
        next_prdata                 = 32'h0000_0000;
        next_pready                 = psel & penable & ~pready;
        if (wr_en) begin
            // Port writes reach the latches but the claim masks them at the pins
            case (paddr)  // R5
                CTRL_STATUS_OFFSET: begin
                    next_channel_select         = pwdata[4:0];  // R8
                    next_continuous_convert_bit = pwdata[CONT_BIT];
                    next_done_interrupt_enable  = pwdata[IEN_BIT];
                end
                CLOCK_DIV_OFFSET:   next_converter_clock_divide = pwdata[2:0];
                PORT_B_DATA_OFFSET: next_port_b.data = pwdata[7:0];
                PORT_B_DIR_OFFSET:  next_port_b.dir  = pwdata[7:0];
                PORT_D_DATA_OFFSET: next_port_d.data = {4'h0, pwdata[3:0]};
                PORT_D_DIR_OFFSET:  next_port_d.dir  = {4'h0, pwdata[3:0]};
                default: ;
            endcase
        end
        if (rd_en && !pready) begin
            case (paddr)
                CTRL_STATUS_OFFSET: next_prdata = {24'h0, conversion_done_flag & ~done_interrupt_enable,
                                                   done_interrupt_enable, continuous_convert_bit,
                                                   channel_select};  // R18
                RESULT_OFFSET:      next_prdata = {24'h0, result};
                CLOCK_DIV_OFFSET:   next_prdata = {29'h0, converter_clock_divide};
                PORT_B_DATA_OFFSET: next_prdata = {24'h0, b_read};  // R6
                PORT_B_DIR_OFFSET:  next_prdata = {24'h0, port_b.dir};
                PORT_D_DATA_OFFSET: next_prdata = {28'h0, d_read8[3:0]};  // R6
                PORT_D_DIR_OFFSET:  next_prdata = {28'h0, port_d.dir[3:0]};
                default:            next_prdata = 32'h0000_0000;
            endcase
        end
        // Completion wins over a clear in the same cycle
        if (finish) begin
            next_conversion_done_flag = 1'b1;  // R16 R2
        end else if (ctrl_write | result_read) begin
            next_conversion_done_flag = 1'b0;  // R16
        end else begin
            next_conversion_done_flag = conversion_done_flag;
        end
        next_irq = next_conversion_done_flag & next_done_interrupt_enable;  // R17
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            state                  <= SCC_IDLE;
            div_count              <= 4'h0;
            step                   <= 4'h0;
            sar                    <= 8'h00;
            trial_bit              <= 8'h80;
            trial_code             <= 8'h00;
            result                 <= 8'h00;
            mux_select             <= CHANNEL_OFF;
            converter_on           <= 1'b0;
            channel_select         <= CHANNEL_OFF;  // R19
            continuous_convert_bit <= 1'b0;
            done_interrupt_enable  <= 1'b0;
            conversion_done_flag   <= 1'b0;
            converter_clock_divide <= CLOCK_DIV_RESET;
            port_b                 <= '0;
            port_d                 <= '0;
            prdata                 <= 32'h0000_0000;
            pready                 <= 1'b0;
            done_irq               <= 1'b0;
            port_b_pins_out        <= 8'h00;
            port_b_pins_oe_n       <= 8'hFF;
            port_d_pins_out        <= 4'h0;
            port_d_pins_oe_n       <= 4'hF;
        end else begin
            state                  <= next_state;
            div_count              <= next_div_count;
            step                   <= next_step;
            sar                    <= next_sar;
            trial_bit              <= next_trial_bit;
            trial_code             <= next_trial_code;
            result                 <= next_result;
            mux_select             <= next_mux_select;
            converter_on           <= next_converter_on;
            channel_select         <= next_channel_select;
            continuous_convert_bit <= next_continuous_convert_bit;
            done_interrupt_enable  <= next_done_interrupt_enable;
            conversion_done_flag   <= next_conversion_done_flag;
            converter_clock_divide <= next_converter_clock_divide;
            port_b                 <= next_port_b;
            port_d                 <= next_port_d;
            prdata                 <= next_prdata;
            pready                 <= next_pready;
            done_irq               <= next_irq;
            port_b_pins_out        <= port_b_out_c;  // R7
            port_b_pins_oe_n       <= port_b_oe_c;
            port_d_pins_out        <= d_out8[3:0];
            port_d_pins_oe_n       <= d_oe8[3:0];
        end
    end

    // One wait state so registered read data stands with pready; nothing is refused
    assign pslverr = 1'b0;

    // ************************************************************
    // Assertions
    // ************************************************************
    done_sets_a: assert property (@(posedge pclk) disable iff (!presetn)
        finish |=> conversion_done_flag && result == $past(sar))  // R2
        else $error("done flag or result missing after conversion");
    done_clear_a: assert property (@(posedge pclk) disable iff (!presetn)
        (result_read && !finish) |=> !conversion_done_flag)  // R16
        else $error("result read did not clear done flag");
    irq_follow_a: assert property (@(posedge pclk) disable iff (!presetn)
        finish && done_interrupt_enable && !ctrl_write |=> done_irq)  // R17
        else $error("interrupt not raised at end of conversion");
    off_idle_a: assert property (@(posedge pclk) disable iff (!presetn)
        ctrl_write && pwdata[4:0] == CHANNEL_OFF |=> state == SCC_IDLE && !finish)  // R19
        else $error("converter ran with channel select all ones");
    start_tick_a: assert property (@(posedge pclk) disable iff (!presetn)
        state == SCC_PENDING && tick && !ctrl_write |=> state == SCC_CONVERT && step == 4'h0)  // R12
        else $error("conversion did not start on converter clock");
    fast_len_a: assert property (@(posedge pclk) disable iff (!presetn)
        converter_clock_divide == 3'h0 && state == SCC_PENDING && !wr_en
        ##1 (!wr_en)[*7] ##1 (!wr_en)[*7] |-> finish)  // R11
        else $error("conversion length not fourteen converter clocks");
    cont_again_a: assert property (@(posedge pclk) disable iff (!presetn)
        finish && continuous_convert_bit && !ctrl_write |=> state == SCC_CONVERT)  // R13 R22
        else $error("continuous mode did not restart");
    single_stop_a: assert property (@(posedge pclk) disable iff (!presetn)
        finish && !continuous_convert_bit && !ctrl_write |=> state == SCC_IDLE)  // R15
        else $error("single conversion did not stop");
    claim_pin_a: assert property (@(posedge pclk) disable iff (!presetn)
        channel_select < 5'h08 ##1 $stable(channel_select) |-> port_b_pins_oe_n[channel_select[2:0]])  // R4 R5
        else $error("claimed pin still driven by port");
endmodule

// ===== verif/sar_conversion_control_tb.sv
// Self-checking bench for the conversion control block
`timescale 1ns/100ps
module sar_conversion_control_tb;
    import scc_pkg::*;
    logic        pclk, presetn, psel, penable, pwrite, pready, pslverr, cmp_above, converter_on, done_irq;
    logic [7:0]  paddr, trial_code, b_in, b_out, b_oe_n;
    logic [31:0] pwdata, prdata, rd;
    logic [4:0]  mux_select;
    logic [3:0]  d_in, d_out, d_oe_n;
    int          failures, checks_done, cyc;
    scc_top dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .cmp_above(cmp_above), .trial_code(trial_code), .mux_select(mux_select), .converter_on(converter_on),
        .port_b_pins_in(b_in), .port_b_pins_out(b_out), .port_b_pins_oe_n(b_oe_n), .port_d_pins_in(d_in),
        .port_d_pins_out(d_out), .port_d_pins_oe_n(d_oe_n), .done_irq(done_irq));
    scc_analog_model model (.trial_code(trial_code), .mux_select(mux_select), .converter_on(converter_on),
        .cmp_above(cmp_above), .b_out(b_out), .b_oe_n(b_oe_n), .d_out(d_out), .d_oe_n(d_oe_n),
        .b_in(b_in), .d_in(d_in));
    initial begin
        pclk = 1'b0;
        forever #25 pclk = ~pclk;
    end
    task automatic test_done();
        $display("checks %0d mismatches %0d", checks_done, failures);
        if (failures == 0 && checks_done > 0) $display("Run complete: PASS");
        else $display("Run complete: FAIL");
        $finish;
    endtask
    task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
        checks_done++;
        if (got !== exp) begin
            failures++;
            $display("MISMATCH %s expected %0h seen %0h", what, exp, got);
        end
    endtask
    // ************************************************************
    // APB master
    // ************************************************************
    task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] wd);
        int n;
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= wd;
        @(posedge pclk);
        penable <= 1'b1;
        n = 0;
        do begin
            @(posedge pclk);
            n++;
        end while (pready !== 1'b1 && n < 50);
        if (n >= 50) begin
            failures++;
            test_done();
        end
        // Read data and response taken at the edge that sees pready high
        rd = prdata;
        check("pslverr", 0, pslverr);
        psel <= 1'b0;
        penable <= 1'b0;
        // Idle edge between transfers; outputs then show the access
        @(posedge pclk);
    endtask
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        apb(1'b1, a, {24'h0, d});
    endtask
    task automatic rdc(input string what, input logic [7:0] a, input logic [7:0] exp);
        apb(1'b0, a, 32'h0);
        check(what, {24'h0, exp}, rd);
    endtask
    // Starts a conversion with interrupt enabled and counts cycles until the request
    task automatic convert(input logic [7:0] ctrl);
        wr(CTRL_STATUS_OFFSET, ctrl | 8'h40);
        cyc = 0;
        while (done_irq !== 1'b1 && cyc < 2000) begin
            @(posedge pclk);
            cyc++;
        end
        if (cyc >= 2000) begin
            failures++;
            test_done();
        end
    endtask
    // ************************************************************
    // Scenarios
    // ************************************************************
    task automatic t_reset();
        check("on", 0, converter_on);
        rdc("ctrl reset", CTRL_STATUS_OFFSET, 8'h1F);
        rdc("div reset", CLOCK_DIV_OFFSET, 8'h00);
        wr(8'h80, 8'h55);
        rdc("unmapped", 8'h80, 8'h00);
    endtask
    task automatic t_levels();
        logic [4:0] ch [6] = '{5'h03, CHANNEL_HIGH_REF, CHANNEL_LOW_REF, 5'h00, CHANNEL_TWELVE, 5'h0B};
        int         lv [6] = '{'hA5, 255, 0, 'h3FF, 'h5A, -5};
        logic [7:0] ex [6] = '{8'hA5, 8'hFF, 8'h00, 8'hFF, 8'h5A, 8'h00};
        for (int i = 0; i < 6; i++) begin
            model.level[ch[i]] = lv[i];
            convert({3'b000, ch[i]});
            check("mux", ch[i], mux_select);
            rdc("result", RESULT_OFFSET, ex[i]);
        end
    endtask
    task automatic t_divider();
        int r;
        model.level[3] = 'h66;
        for (int d = 0; d < 8; d++) begin
            r = (d > 3) ? 16 : (1 << d);
            wr(CLOCK_DIV_OFFSET, d[7:0]);
            convert(8'h03);
            check("cycles in window", 1, (cyc >= 14 * r && cyc <= 15 * r + 4));
            rdc("div result", RESULT_OFFSET, 8'h66);
        end
        wr(CLOCK_DIV_OFFSET, 8'h00);
    endtask
    task automatic t_flags();
        int n;
        wr(CTRL_STATUS_OFFSET, 8'h03);
        n = 0;
        do begin
            apb(1'b0, CTRL_STATUS_OFFSET, 32'h0);
            n++;
        end while (rd[DONE_BIT] !== 1'b1 && n < 40);
        check("done set", 8'h83, rd);
        rdc("done held", CTRL_STATUS_OFFSET, 8'h83);
        rdc("result", RESULT_OFFSET, 8'h66);
        rdc("done cleared", CTRL_STATUS_OFFSET, 8'h03);
        convert(8'h03);
        rdc("done hidden", CTRL_STATUS_OFFSET, 8'h43);
        check("irq held", 1, done_irq);
        rdc("result", RESULT_OFFSET, 8'h66);
        check("irq read clear", 0, done_irq);
        convert(8'h03);
        wr(CTRL_STATUS_OFFSET, 8'h43);
        check("irq write clear", 0, done_irq);
        repeat (20) @(posedge pclk);
    endtask
    task automatic t_cont();
        model.level[3] = 'h10;
        convert(8'h23);
        model.level[3] = 'h20;
        rdc("cont first", RESULT_OFFSET, 8'h10);
        convert(8'h23);
        model.level[3] = 'h30;
        repeat (40) @(posedge pclk);
        rdc("cont overwrite", RESULT_OFFSET, 8'h30);
        convert(8'h03);
        rdc("single", RESULT_OFFSET, 8'h30);
        repeat (60) @(posedge pclk);
        check("no repeat", 0, done_irq);
    endtask
    task automatic t_abort();
        model.level[4] = 'h77;
        model.level[5] = 'h3C;
        wr(CTRL_STATUS_OFFSET, 8'h44);
        repeat (5) @(posedge pclk);
        convert(8'h05);
        check("restart time", 1, (cyc >= 14 && cyc <= 19));
        rdc("restart result", RESULT_OFFSET, 8'h3C);
    endtask
    task automatic t_ports();
        wr(CTRL_STATUS_OFFSET, 8'h02);
        wr(PORT_B_DIR_OFFSET, 8'hFB);
        wr(PORT_B_DATA_OFFSET, 8'hFF);
        check("oe_n claim", 8'h04, b_oe_n);
        rdc("claimed dir0", PORT_B_DATA_OFFSET, 8'hFB);
        wr(PORT_B_DIR_OFFSET, 8'hFF);
        @(posedge pclk);
        check("oe_n kept", 8'h04, b_oe_n);
        check("out claim", 8'hFB, b_out);
        rdc("claimed dir1", PORT_B_DATA_OFFSET, 8'hFF);
        wr(PORT_D_DIR_OFFSET, 8'h0F);
        wr(PORT_D_DATA_OFFSET, 8'h0F);
        wr(CTRL_STATUS_OFFSET, 8'h08);
        repeat (2) @(posedge pclk);
        check("d oe_n claim", 4'h8, d_oe_n);
        check("d out claim", 4'h7, d_out);
        rdc("d claimed dir1", PORT_D_DATA_OFFSET, 8'h0F);
        wr(CTRL_STATUS_OFFSET, 8'h1F);
        repeat (2) @(posedge pclk);
        check("off", 0, converter_on);
        check("oe_n free", 8'h00, b_oe_n);
    endtask
    initial begin
        presetn = 1'b0;
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 8'h00;
        pwdata = 32'h0;
        failures = 0;
        checks_done = 0;
        repeat (6) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        t_reset();
        t_levels();
        t_divider();
        t_flags();
        t_cont();
        t_abort();
        t_ports();
        test_done();
    end
endmodule

// ===== verif/scc_analog_model.sv
// Behavioural analog front end: channel levels, comparator and pin wiring
`timescale 1ns/100ps
module scc_analog_model
    import scc_pkg::*;
(
    // Converter side
    input  wire logic [7:0] trial_code,
    input  wire logic [4:0] mux_select,
    input  wire logic       converter_on,
    output logic            cmp_above,
    // Pins
    input  wire logic [7:0] b_out,
    input  wire logic [7:0] b_oe_n,
    input  wire logic [3:0] d_out,
    input  wire logic [3:0] d_oe_n,
    output logic [7:0]      b_in,
    output logic [3:0]      d_in
);
    int         level [32];
    logic [7:0] b_ext;
    logic [3:0] d_ext;
    initial begin
        foreach (level[i]) level[i] = 0;
        level[CHANNEL_HIGH_REF] = 255;
        level[CHANNEL_LOW_REF]  = 0;
        b_ext = 8'h00;
        d_ext = 4'h0;
    end
    // Level n sits mid-code n, so trial n passes; ints beyond the supplies saturate; off gives trial code bit 0
    always_comb cmp_above = converter_on ? (level[mux_select] >= int'(trial_code)) : trial_code[0];
    // Wire level: design wins where it drives, else the outside source
    always_comb b_in = (b_oe_n & b_ext) | (~b_oe_n & b_out);
    always_comb d_in = (d_oe_n & d_ext) | (~d_oe_n & d_out);
endmodule
